// ---- ata_host_model.sv ----
// host adapter model that drives the drive's task file pins
`timescale 1ns/1ps
module ata_host_model
(
    // clock
    input wire logic clk,
    // pins toward the drive
    output logic cs0_n,
    output logic cs1_n,
    output logic [2:0] addr,
    output logic read_n,
    output logic write_n,
    output logic [15:0] dataIn,
    // pins from the drive
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe,
    input wire logic wide16_n,
    // captured read result, valid for one cycle
    output logic rdDone,
    output logic [15:0] rdData,
    output logic [15:0] rdOe,
    output logic rdWide
);
    // idle pins at time zero
    initial
    begin
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        addr = 3'h0;
        read_n = 1'b1;
        write_n = 1'b1;
        dataIn = 16'h0000;
        rdDone = 1'b0;
    end

    // ************************************************************
    // one programmed access: index and select first, then a strobe
    // ************************************************************
    task automatic access(input logic c0, input logic c1, input logic [2:0] a,
                          input logic wr, input logic [15:0] d);
        @(posedge clk);
        cs0_n <= c0;
        cs1_n <= c1;
        addr <= a;
        dataIn <= d;
        repeat (3) @(posedge clk);
        if (wr)
            write_n <= 1'b0;
        else
            read_n <= 1'b0;
        repeat (6) @(posedge clk);
        // upper byte only means something while the indicator is low
        rdData <= dataOut;
        rdOe <= dataOe;
        rdWide <= wide16_n;
        rdDone <= !wr;
        read_n <= 1'b1;
        write_n <= 1'b1;
        @(posedge clk);
        rdDone <= 1'b0;
        repeat (6) @(posedge clk);
        // released data shows the inverse so a stale value cannot pass
        cs0_n <= 1'b1;
        cs1_n <= 1'b1;
        dataIn <= ~d;
    endtask
endmodule

// ---- ata_task_file_decode.sv ----
// drive side task file decoder on the parallel disk interface
`timescale 1ns/1ps
module ata_task_file_decode
    import ata_task_file_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter logic [7:0] LEGACY_ADDR = 8'h5a // arbitrary value
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host interface pins; selects, strobes and reset active low as on the cable
    input wire logic hostCs0_n,
    input wire logic hostCs1_n,
    input wire logic [2:0] hostAddr,
    input wire logic hostRead_n,
    input wire logic hostWrite_n,
    input wire logic hostReset_n,
    input wire logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic [15:0] hostDataOe,
    output logic wide16_n,
    // drive firmware side: words written by the host
    output logic hostWordValid,
    input wire logic hostWordReady,
    output logic [15:0] hostWord,
    // drive firmware side: words for the host to read
    input wire logic driveWordValid,
    input wire logic [15:0] driveWord,
    output logic driveWordTaken,
    // drive firmware side: command and status
    input wire logic [7:0] lastError,
    input wire logic [7:0] driveStatus,
    input wire logic byteMode,
    input wire logic busyClear,
    output logic commandStrobe,
    output logic [7:0] commandCode,
    output logic [55:0] taskRegs
);

    initial
    begin
        if (FIFO_DEPTH < 2)
            $error("fifo depth too small");
    end

    // ************************************************************
    // synchronisers and state
    // ************************************************************
    typedef struct packed {
        host_pins_type pinsMeta;
        host_pins_type pins;
        logic resetMeta;
        logic resetSync;
        logic readPrev;
        logic writePrev;
        logic resetPrev;
        logic busy;
        task_regs_type regs;
        logic [15:0] dataOut;
        logic [15:0] dataOe;
        logic wide16_n;
        logic cmdStrobe;
        logic [7:0] cmdCode;
        logic wordTaken;
    } state_type;

    state_type state;
    state_type next_state;
    host_pins_type rawPins;
    reg_sel_type sel;
    logic fifoInValid;
    logic fifoInReady;
    logic readStart;
    logic readEnd;
    logic writeStart;
    logic resetRelease;
    logic [7:0] mergedStatus;

    assign rawPins = '{cs0Active: !hostCs0_n, cs1Active: !hostCs1_n, addr: hostAddr,
                       readStrobe: !hostRead_n, writeStrobe: !hostWrite_n,
                       dataIn: hostDataIn};

    // decode chip selects and index into one register choice
    function automatic reg_sel_type decode(input host_pins_type p);
        reg_sel_type s;
        s = SEL_NONE;
        if (p.cs0Active && !p.cs1Active)
        begin
            unique case (p.addr)
                IDX_DATA: s = SEL_DATA;
                IDX_ERR_FEAT: s = SEL_ERR_FEAT;
                IDX_COUNT: s = SEL_COUNT;
                IDX_SECTOR: s = SEL_SECTOR;
                IDX_TRK_LOW: s = SEL_TRK_LOW;
                IDX_TRK_HIGH: s = SEL_TRK_HIGH;
                IDX_UNIT_HEAD: s = SEL_UNIT_HEAD;
                IDX_STAT_CMD: s = SEL_STAT_CMD;
            endcase
        end
        else if (p.cs1Active && !p.cs0Active)
        begin
            if (p.addr == IDX_ALT_CTRL)
                s = SEL_ALT_CTRL;
            else if (p.addr == IDX_LEGACY)
                s = SEL_LEGACY;
            // other indices stay SEL_NONE
        end
        // both or neither select leaves SEL_NONE
        return s;
    endfunction

    assign sel = decode(state.pins);
    // strobe edges after the synchronisers
    assign readStart = state.pins.readStrobe && !state.readPrev;
    assign readEnd = !state.pins.readStrobe && state.readPrev;
    assign writeStart = state.pins.writeStrobe && !state.writePrev;
    assign resetRelease = state.resetSync && !state.resetPrev;
    // busy bit forced into both status views while reset recovery runs
    assign mergedStatus = {state.busy | driveStatus[STAT_BUSY_BIT], driveStatus[6:0]};

    // ************************************************************
    // host write data buffer
    // ************************************************************
    // a write to the data port while the buffer is full is dropped; the host
    // is expected to pace itself on the status data request bit
    assign fifoInValid = writeStart && sel == SEL_DATA;

    ata_word_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) writeBuffer (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(byteMode ? {8'h00, state.pins.dataIn[7:0]} : state.pins.dataIn),
        .outValid(hostWordValid),
        .outReady(hostWordReady),
        .outData(hostWord)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_state = state;
        next_state.pinsMeta = rawPins;
        next_state.pins = state.pinsMeta;
        next_state.resetMeta = hostReset_n;
        next_state.resetSync = state.resetMeta;
        next_state.readPrev = state.pins.readStrobe;
        next_state.writePrev = state.pins.writeStrobe;
        next_state.resetPrev = state.resetSync;
        next_state.cmdStrobe = 1'b0;
        next_state.wordTaken = 1'b0;

        // indicator follows decoded address, dropped for byte transfers
        next_state.wide16_n = !(sel == SEL_DATA && !byteMode);

        // hardware reset clears the task file, loads count and sector with one, and raises busy quickly
        if (!state.resetSync)
        begin
            next_state.regs = '0;
            next_state.regs.transferCount = COUNT_RESET;
            next_state.regs.targetSector = SECTOR_RESET;
            next_state.busy = 1'b1;
        end
        else if (resetRelease)
        begin
            next_state.busy = 1'b1;
        end
        else if (busyClear)
        begin
            next_state.busy = 1'b0;
        end

        // register writes on the strobe's leading edge only
        if (writeStart && state.resetSync)
        begin
            unique case (sel)
                SEL_ERR_FEAT: next_state.regs.featureSelect = state.pins.dataIn[7:0];
                SEL_COUNT: next_state.regs.transferCount = state.pins.dataIn[7:0];
                SEL_SECTOR: next_state.regs.targetSector = state.pins.dataIn[7:0];
                SEL_TRK_LOW: next_state.regs.trackLow = state.pins.dataIn[7:0];
                SEL_TRK_HIGH: next_state.regs.trackHigh = state.pins.dataIn[7:0];
                SEL_UNIT_HEAD: next_state.regs.unitAndHead = state.pins.dataIn[7:0];
                SEL_STAT_CMD:
                begin
                    next_state.cmdCode = state.pins.dataIn[7:0];
                    next_state.cmdStrobe = 1'b1;
                end
                // unused control bits are not stored
                SEL_ALT_CTRL: next_state.regs.interfaceControl =
                    state.pins.dataIn[7:0] & CTRL_USED_MASK;
                SEL_DATA, SEL_LEGACY, SEL_NONE: ;
            endcase
        end

        // read data driven from strobe start until strobe end
        if (readStart)
        begin
            next_state.dataOe = 16'h00ff;
            next_state.dataOut = 16'h0000; // unused bits read zero
            unique case (sel)
                SEL_DATA:
                begin
                    // byte-wide phase hands over the low byte only, upper reads zero
                    next_state.dataOut = byteMode ? {8'h00, driveWord[7:0]} : driveWord;
                    // upper byte only driven on a wide transfer
                    next_state.dataOe = byteMode ? 16'h00ff : 16'hffff;
                    next_state.wordTaken = driveWordValid;
                end
                SEL_ERR_FEAT: next_state.dataOut[7:0] = lastError;
                SEL_COUNT: next_state.dataOut[7:0] = state.regs.transferCount;
                SEL_SECTOR: next_state.dataOut[7:0] = state.regs.targetSector;
                SEL_TRK_LOW: next_state.dataOut[7:0] = state.regs.trackLow;
                SEL_TRK_HIGH: next_state.dataOut[7:0] = state.regs.trackHigh;
                SEL_UNIT_HEAD: next_state.dataOut[7:0] = state.regs.unitAndHead;
                SEL_STAT_CMD, SEL_ALT_CTRL: next_state.dataOut[7:0] = mergedStatus;
                SEL_LEGACY:
                begin
                    // bit 7 released to avoid fighting a floppy controller
                    next_state.dataOut[7:0] = LEGACY_ADDR;
                    next_state.dataOe[LEGACY_SAFE_BIT] = 1'b0;
                end
                SEL_NONE: next_state.dataOe = 16'h0000;
            endcase
        end
        else if (readEnd || !state.pins.readStrobe)
        begin
            next_state.dataOe = 16'h0000;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state <= '0;
            state.resetMeta <= 1'b1;
            state.resetSync <= 1'b1;
            state.resetPrev <= 1'b1;
            state.wide16_n <= 1'b1;
            state.regs.transferCount <= COUNT_RESET;
            state.regs.targetSector <= SECTOR_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign hostDataOut = state.dataOut;
    assign hostDataOe = state.dataOe;
    assign wide16_n = state.wide16_n;
    assign commandStrobe = state.cmdStrobe;
    assign commandCode = state.cmdCode;
    assign driveWordTaken = state.wordTaken;
    assign taskRegs = state.regs;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_reset_released;
        state.resetSync && !state.resetPrev;
    endsequence

    property p_busy_after_reset;
        @(posedge clk) disable iff (sys_rst)
        s_reset_released |=> state.busy;
    endproperty
    a_busy_after_reset: assert property (p_busy_after_reset)
        else $error("busy not set after hardware reset release");

    property p_invalid_no_drive;
        @(posedge clk) disable iff (sys_rst)
        (readStart && sel == SEL_NONE) |=> hostDataOe == 16'h0000;
    endproperty
    a_invalid_no_drive: assert property (p_invalid_no_drive)
        else $error("bus driven on invalid address");

    property p_legacy_bit7;
        @(posedge clk) disable iff (sys_rst)
        (readStart && sel == SEL_LEGACY) |=> !hostDataOe[LEGACY_SAFE_BIT];
    endproperty
    a_legacy_bit7: assert property (p_legacy_bit7)
        else $error("legacy read drove bit 7");

    property p_both_selects;
        @(posedge clk) disable iff (sys_rst)
        (state.pins.cs0Active && state.pins.cs1Active) |-> sel == SEL_NONE;
    endproperty
    a_both_selects: assert property (p_both_selects)
        else $error("both selects decoded as valid");

    property p_wide_indicator;
        @(posedge clk) disable iff (sys_rst)
        (sel == SEL_DATA && !byteMode) |=> !wide16_n;
    endproperty
    a_wide_indicator: assert property (p_wide_indicator)
        else $error("16-bit indicator not asserted for data port");

    property p_byte_mode_narrow;
        @(posedge clk) disable iff (sys_rst)
        byteMode |=> wide16_n;
    endproperty
    a_byte_mode_narrow: assert property (p_byte_mode_narrow)
        else $error("16-bit indicator active in byte mode");

    property p_upper_byte;
        @(posedge clk) disable iff (sys_rst)
        hostDataOe[15] |-> $past(sel) == SEL_DATA;
    endproperty
    a_upper_byte: assert property (p_upper_byte)
        else $error("upper byte driven outside data port");

    property p_release_on_end;
        @(posedge clk) disable iff (sys_rst)
        readEnd |=> hostDataOe == 16'h0000;
    endproperty
    a_release_on_end: assert property (p_release_on_end)
        else $error("bus not released after read strobe");

    property p_command_pulse;
        @(posedge clk) disable iff (sys_rst)
        (writeStart && sel == SEL_STAT_CMD && state.resetSync)
            |=> commandStrobe && commandCode == $past(state.pins.dataIn[7:0]) ##1 !commandStrobe;
    endproperty
    a_command_pulse: assert property (p_command_pulse)
        else $error("command write not issued as one pulse");

    property p_control_mask;
        @(posedge clk) disable iff (sys_rst)
        (state.regs.interfaceControl & ~CTRL_USED_MASK) == 8'h00;
    endproperty
    a_control_mask: assert property (p_control_mask)
        else $error("unused control bits stored");

    property p_busy_in_reset;
        @(posedge clk) disable iff (sys_rst)
        !state.resetSync |=> state.busy;
    endproperty
    a_busy_in_reset: assert property (p_busy_in_reset)
        else $error("busy not held during hardware reset");

    property p_byte_read_narrow;
        @(posedge clk) disable iff (sys_rst)
        (readStart && sel == SEL_DATA && byteMode)
            |=> hostDataOe == 16'h00ff && hostDataOut[15:8] == 8'h00;
    endproperty
    a_byte_read_narrow: assert property (p_byte_read_narrow)
        else $error("upper byte used in byte-wide data read");

    property p_ignored_write;
        @(posedge clk) disable iff (sys_rst)
        (writeStart && state.resetSync && (sel == SEL_NONE || sel == SEL_LEGACY))
            |=> $stable(taskRegs) && !commandStrobe;
    endproperty
    a_ignored_write: assert property (p_ignored_write)
        else $error("register changed on an ignored write");

endmodule

// ---- ata_task_file_decode_tb.sv ----
// self-checking bench for the task file decoder
`timescale 1ns/1ps
module ata_task_file_decode_tb
    import ata_task_file_pkg::*;
;
    // expected read result; masks pick the bits that matter
    typedef struct packed {
        logic wide;
        logic [15:0] oeMask;
        logic [15:0] oe;
        logic [15:0] dMask;
        logic [15:0] d;
    } exp_type;
    localparam exp_type NONE = '{1'b1, 16'hffff, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [7:0] LEGACY = 8'h5a; // arbitrary value
    logic clk, sys_rst, hostReset_n, hostWordReady, driveWordValid, byteMode, busyClear;
    logic hostCs0_n, hostCs1_n, hostRead_n, hostWrite_n, wide16_n, hostWordValid;
    logic driveWordTaken, commandStrobe, rdDone, rdWide;
    logic [2:0] hostAddr;
    logic [15:0] hostDataIn, hostDataOut, hostDataOe, hostWord, driveWord, rdData, rdOe, d16;
    logic [7:0] lastError, driveStatus, commandCode, cmdExp;
    logic [55:0] taskRegs, regsExp;
    logic [7:0] v [1:6];
    exp_type e;
    exp_type expQ [$];
    logic [15:0] wordQ [$];
    int seed = 55;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int cmdSeen = 0;
    int takenSeen = 0;

    ata_task_file_decode #(.FIFO_DEPTH(16), .LEGACY_ADDR(LEGACY)) dut (.clk(clk),
        .sys_rst(sys_rst), .hostCs0_n(hostCs0_n), .hostCs1_n(hostCs1_n), .hostAddr(hostAddr),
        .hostRead_n(hostRead_n), .hostWrite_n(hostWrite_n), .hostReset_n(hostReset_n),
        .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .wide16_n(wide16_n), .hostWordValid(hostWordValid), .hostWordReady(hostWordReady),
        .hostWord(hostWord), .driveWordValid(driveWordValid), .driveWord(driveWord),
        .driveWordTaken(driveWordTaken), .lastError(lastError), .driveStatus(driveStatus),
        .byteMode(byteMode), .busyClear(busyClear), .commandStrobe(commandStrobe),
        .commandCode(commandCode), .taskRegs(taskRegs));
    ata_host_model host (.clk(clk), .cs0_n(hostCs0_n), .cs1_n(hostCs1_n), .addr(hostAddr),
        .read_n(hostRead_n), .write_n(hostWrite_n), .dataIn(hostDataIn),
        .dataOut(hostDataOut), .dataOe(hostDataOe), .wide16_n(wide16_n), .rdDone(rdDone),
        .rdData(rdData), .rdOe(rdOe), .rdWide(rdWide));

    // ************************************************************
    // helpers
    // ************************************************************
    task check(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    function automatic exp_type reg8(input logic [7:0] x);
        return '{1'b1, 16'h00ff, 16'h00ff, 16'h00ff, {8'h00, x}};
    endfunction
    // a read also proves the bus is let go once the strobe ends
    task rd(input logic c0, input logic c1, input logic [2:0] a, input exp_type x);
        expQ.push_back(x);
        host.access(c0, c1, a, 1'b0, 16'h0000);
        check(hostDataOe === 16'h0000, "bus kept");
    endtask
    task wr(input logic c0, input logic c1, input logic [2:0] a, input logic [15:0] d);
        host.access(c0, c1, a, 1'b1, d);
    endtask
    task end_sim();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // watchers: finished reads, drained words, commands, and the hang limit
    always @(posedge clk)
    begin
        if (rdDone === 1'b1)
        begin
            e = expQ.pop_front();
            check(((rdOe ^ e.oe) & e.oeMask) === 16'h0 && ((rdData ^ e.d) & e.dMask) === 16'h0
                  && rdWide === e.wide, "read value");
        end
        if (hostWordValid === 1'b1 && hostWordReady === 1'b1)
            check(hostWord === wordQ.pop_front(), "fifo word");
        if (commandStrobe === 1'b1)
        begin
            cmdSeen++;
            check(commandCode === cmdExp, "command code");
        end
        if (driveWordTaken === 1'b1)
            takenSeen++;
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        hostReset_n = 1'b1;
        hostWordReady = 1'b0;
        driveWordValid = 1'b1;
        byteMode = 1'b0;
        busyClear = 1'b0;
        driveWord = 16'h0000;
        lastError = 8'h04;
        driveStatus = 8'h50;
        cmdExp = 8'h00;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(0, 1, IDX_COUNT, reg8(COUNT_RESET));
        rd(0, 1, IDX_SECTOR, reg8(SECTOR_RESET));
        for (int i = 1; i <= 6; i++)
        begin
            v[i] = 8'($random(seed));
            wr(0, 1, 3'(i), {8'ha5, v[i]});
        end
        check(taskRegs === {v[1], v[2], v[3], v[4], v[5], v[6], 8'h00}, "task file");
        for (int i = 2; i <= 6; i++)
            rd(0, 1, 3'(i), reg8(v[i]));
        rd(0, 1, IDX_ERR_FEAT, reg8(lastError));
        rd(0, 1, IDX_STAT_CMD, reg8(driveStatus));
        rd(1, 0, IDX_ALT_CTRL, reg8(driveStatus));
        cmdExp = 8'($random(seed));
        wr(0, 1, IDX_STAT_CMD, {8'h00, cmdExp});
        check(cmdSeen == 1, "command count");
        wr(1, 0, IDX_ALT_CTRL, 16'hffff);
        check(taskRegs[7:0] === CTRL_USED_MASK, "control bits");
        regsExp = {v[1], v[2], v[3], v[4], v[5], v[6], CTRL_USED_MASK};
        rd(1, 0, IDX_LEGACY, '{1'b1, 16'h0080, 16'h0000, 16'h007f, {8'h00, LEGACY}});
        for (int i = 0; i < 8; i++)
        begin
            if (i < 6)
                rd(1, 0, 3'(i), NONE);
            if (i != 6)
                wr(1, 0, 3'(i), 16'h0000);
            rd(0, 0, 3'(i), NONE);
            wr(1, 1, 3'(i), 16'h0000);
        end
        check(taskRegs === regsExp, "ignored writes");
        driveWord <= 16'($random(seed));
        @(posedge clk);
        rd(0, 1, IDX_DATA, '{1'b0, 16'hffff, 16'hffff, 16'hffff, driveWord});
        byteMode <= 1'b1;
        rd(0, 1, IDX_DATA,
           '{1'b1, 16'hffff, 16'h00ff, 16'hffff, {8'h00, driveWord[7:0]}});
        byteMode <= 1'b0;
        check(takenSeen == 2, "word taken");
        // the far side stalls while the buffer fills; the last word is refused
        for (int i = 0; i < 17; i++)
        begin
            d16 = 16'($random(seed));
            if (i < 16)
                wordQ.push_back(d16);
            wr(0, 1, IDX_DATA, d16);
        end
        hostWordReady <= 1'b1;
        repeat (40) @(posedge clk);
        check(wordQ.size() == 0, "fifo drain");
        hostReset_n <= 1'b0;
        repeat (1000) @(posedge clk);
        hostReset_n <= 1'b1;
        rd(0, 1, IDX_STAT_CMD, '{1'b1, 16'h0080, 16'h0080, 16'h0080, 16'h0080});
        check(taskRegs[55:32] === {8'h00, COUNT_RESET, SECTOR_RESET}, "reset clear");
        busyClear <= 1'b1;
        @(posedge clk);
        busyClear <= 1'b0;
        rd(0, 1, IDX_STAT_CMD, reg8(driveStatus));
        repeat (10) @(posedge clk);
        end_sim();
    end
endmodule

// ---- ata_task_file_pkg.sv ----
// shared constants, types and state layout for the drive task file decoder
package ata_task_file_pkg;

    // ************************************************************
    // clock and reset timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int BUSY_LATENCY_NS = 400;
    // longest time rounds down, never below one cycle
    localparam int BUSY_LATENCY_CYC_RAW = (BUSY_LATENCY_NS * 1000) / CLK_PERIOD_PS;
    localparam int BUSY_LATENCY_CYC = (BUSY_LATENCY_CYC_RAW < 1) ? 1 : BUSY_LATENCY_CYC_RAW;
    localparam int RESET_PULSE_US = 25;

    // ************************************************************
    // register indices on the three address lines
    // ************************************************************
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_ERR_FEAT = 3'h1;
    localparam logic [2:0] IDX_COUNT = 3'h2;
    localparam logic [2:0] IDX_SECTOR = 3'h3;
    localparam logic [2:0] IDX_TRK_LOW = 3'h4;
    localparam logic [2:0] IDX_TRK_HIGH = 3'h5;
    localparam logic [2:0] IDX_UNIT_HEAD = 3'h6;
    localparam logic [2:0] IDX_STAT_CMD = 3'h7;
    localparam logic [2:0] IDX_ALT_CTRL = 3'h6;
    localparam logic [2:0] IDX_LEGACY = 3'h7;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int STAT_BUSY_BIT = 7;
    localparam int LEGACY_SAFE_BIT = 7;
    localparam logic [7:0] CTRL_USED_MASK = 8'h06;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h01;
    localparam logic [7:0] SECTOR_RESET = 8'h01;

    // decoded register selected by chip selects and index
    typedef enum {
        SEL_NONE,
        SEL_DATA,
        SEL_ERR_FEAT,
        SEL_COUNT,
        SEL_SECTOR,
        SEL_TRK_LOW,
        SEL_TRK_HIGH,
        SEL_UNIT_HEAD,
        SEL_STAT_CMD,
        SEL_ALT_CTRL,
        SEL_LEGACY
    } reg_sel_type;

    // host side pins after synchronising
    typedef struct packed {
        logic cs0Active;
        logic cs1Active;
        logic [2:0] addr;
        logic readStrobe;
        logic writeStrobe;
        logic [15:0] dataIn;
    } host_pins_type;

    // task file register set
    typedef struct packed {
        logic [7:0] featureSelect;
        logic [7:0] transferCount;
        logic [7:0] targetSector;
        logic [7:0] trackLow;
        logic [7:0] trackHigh;
        logic [7:0] unitAndHead;
        logic [7:0] interfaceControl;
    } task_regs_type;

endpackage

// ---- ata_word_fifo.sv ----
// first-in first-out buffer for sector data words
`timescale 1ns/1ps
module ata_word_fifo
    import ata_task_file_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic doWrite;
    logic doRead;

    // ************************************************************
    // pointers and storage
    // ************************************************************
    assign inReady = (wrPtr - rdPtr) != (AW + 1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // one extra pointer bit tells full from empty
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr <= wrPtr + 1'b1;
            if (doRead)
                rdPtr <= rdPtr + 1'b1;
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge clk)
    begin
        if (doWrite)
            mem[wrPtr[AW-1:0]] <= inData;
    end

endmodule
